//--- design/decc_ext_regs.v
// Extension clock control, page select, colour and compatibility register bank.
`include "decc_map.vh"

module decc_ext_regs (
  input  wire        clock,
  input  wire        reset,
  // Indexed sequencer data port.
  input  wire [7:0]  reg_index,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata,
  input  wire        ext_unlocked,
  input  wire        sync_reset_active,
  // Clock select sources from other registers.
  input  wire [7:0]  misc_output,
  input  wire        clock_select_bit4,
  // Extended clock pins as three separate signals.
  input  wire [2:0]  ext_clk_pin_in,
  output reg  [2:0]  ext_clk_pin_out,
  output reg  [2:0]  ext_clk_pin_oe,
  output reg  [3:0]  selected_clock_src,
  // Decoding.
  input  wire        board_enable_pin,
  input  wire        ext_enable_bit,
  output reg         io_decode_en,
  output reg         mem_decode_en,
  // Display enable and refresh timing.
  input  wire [1:0]  hblank_skew,
  output reg  [2:0]  de_skew_chars,
  output reg         refresh_after_unskewed,
  // Solid fill colours.
  input  wire [1:0]  fb_mode,
  output reg  [3:0]  fg_color,
  output reg  [3:0]  bg_color,
  output reg         solid_fill_active,
  // Extended attribute decode.
  input  wire [7:0]  attr_byte,
  output reg         attr_underline,
  output reg         attr_reverse,
  output reg         attr_overline,
  output reg         attr_blink,
  output reg         attr_alt_palette,
  output reg  [2:0]  attr_font,
  // Address multiplexing.
  input  wire [16:0] cpu_addr,
  input  wire [15:0] crtc_count,
  input  wire [15:0] crtc_std_addr,
  input  wire        chain4,
  input  wire        chain_odd_even,
  input  wire        doubleword,
  output wire [15:0] cpu_linear,
  output wire [15:0] crtc_linear
);
  // ****************************************************************
  // Register storage
  // ****************************************************************
  reg  [7:0] clock_mux_control_q;
  reg  [7:0] clk_active_q;
  reg        page_q;
  reg  [3:0] fg_q;
  reg  [3:0] bg_q;
  reg  [7:0] compatibility_options_q;
  reg  [7:0] rdata_d;

  // Index match, shared by every register write strobe below.
  function hit;
    input [7:0] idx;
    input [7:0] want;
    begin
      hit = (idx == want);
    end
  endfunction

  // Solid foreground/background mode decode, used by the flag and both colours.
  function is_solid;
    input [1:0] mode;
    begin
      is_solid = (mode == `DECC_FB_SOLID);
    end
  endfunction

  wire wr_ok = reg_write && ext_unlocked;

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always @(posedge clock) begin
    if (reset) begin
      clock_mux_control_q <= `DECC_RST8;
    end else if (wr_ok && hit(reg_index, `DECC_IDX_CLOCK_MUX_CONTROL)) begin
      clock_mux_control_q <= reg_wdata;
    end
  end

  // Copy to the live clock selection only under synchronous reset, so
  // a write outside reset is held back rather than glitching the mux.
  always @(posedge clock) begin
    if (reset) begin
      clk_active_q <= `DECC_RST8;
    end else if (sync_reset_active) begin
      clk_active_q <= clock_mux_control_q;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      page_q <= `DECC_RST1;
    end else if (wr_ok && hit(reg_index, `DECC_IDX_PAGE)) begin
      page_q <= reg_wdata[`DECC_PAGE_BIT];
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      fg_q <= `DECC_RST4;
    end else if (wr_ok && hit(reg_index, `DECC_IDX_FG)) begin
      fg_q <= reg_wdata[`DECC_COLOR_HI:`DECC_COLOR_LO];
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      bg_q <= `DECC_RST4;
    end else if (wr_ok && hit(reg_index, `DECC_IDX_BG)) begin
      bg_q <= reg_wdata[`DECC_COLOR_HI:`DECC_COLOR_LO];
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      compatibility_options_q <= `DECC_RST8;
    end else if (wr_ok && hit(reg_index, `DECC_IDX_COMPATIBILITY_OPTIONS)) begin
      compatibility_options_q <= reg_wdata;
    end
  end

  // ****************************************************************
  // Read back
  // ****************************************************************
  always @* begin
    rdata_d = `DECC_RST8;
    if (ext_unlocked) begin
      case (reg_index)
        `DECC_IDX_CLOCK_MUX_CONTROL: rdata_d = clock_mux_control_q;
        `DECC_IDX_PAGE:    rdata_d = {7'h00, page_q};
        `DECC_IDX_FG:      rdata_d = {4'h0, fg_q};
        `DECC_IDX_BG:      rdata_d = {4'h0, bg_q};
        `DECC_IDX_COMPATIBILITY_OPTIONS:  rdata_d = compatibility_options_q;
        default:           rdata_d = `DECC_RST8;
      endcase
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      reg_rdata <= `DECC_RST8;
    end else if (reg_read) begin
      reg_rdata <= rdata_d;
    end
  end

  // ****************************************************************
  // Extended clock pins and clock source selection
  // ****************************************************************
  wire       ck_dir  = clk_active_q[`DECC_CK_DIR];
  wire       ck_src  = clk_active_q[`DECC_CK_OUT_SRC];
  wire       m3      = misc_output[`DECC_MISC_SEL_HI];
  wire       m2      = misc_output[`DECC_MISC_SEL_LO];
  wire [2:0] sel_std = {clock_select_bit4, m3, m2};
  reg  [3:0] src_d;

  always @(posedge clock) begin
    if (reset) begin
      ext_clk_pin_out <= `DECC_PINS_IDLE;
      ext_clk_pin_oe  <= `DECC_PINS_IDLE;
    end else if (ck_dir && ck_src) begin
      ext_clk_pin_out <= clk_active_q[`DECC_CK_OUT_HI:`DECC_CK_OUT_LO];
      ext_clk_pin_oe  <= `DECC_PINS_DRIVE;
    end else if (ck_dir) begin
      ext_clk_pin_out <= sel_std;
      ext_clk_pin_oe  <= `DECC_PINS_DRIVE;
    end else begin
      ext_clk_pin_out <= `DECC_PINS_IDLE;
      ext_clk_pin_oe  <= `DECC_PINS_IDLE;
    end
  end

  // Ground and feature decodes take precedence over zero-only and the select bits unless their override bits are set, so a single
  // external generator still looks like a set of crystals to old software.
  always @* begin
    src_d = `DECC_SRC_PRIMARY;
    if (m3 && m2 && !clk_active_q[`DECC_CK_CLK3_ON]) begin
      src_d = `DECC_SRC_GROUND;
    end else if (m3 && !m2 && !clk_active_q[`DECC_CK_EXT_OVR]) begin
      src_d = `DECC_SRC_FEATURE;
    end else if (clk_active_q[`DECC_CK_ZERO_ONLY]) begin
      src_d = `DECC_SRC_PRIMARY;
    end else if (ck_dir) begin
      // Generator code on the driven pins, eight frequencies.
      src_d = `DECC_SRC_GEN_BASE | {1'b0, sel_std};
    end else begin
      case (sel_std)
        3'h0:    src_d = `DECC_SRC_PRIMARY;
        3'h1:    src_d = `DECC_SRC_SECOND;
        3'h2:    src_d = `DECC_SRC_FEATURE;
        3'h3:    src_d = `DECC_SRC_THIRD;
        // Extended pins as clock inputs.
        default: src_d = `DECC_SRC_PIN_BASE | {2'h0, sel_std[1:0]};
      endcase
    end
  end

  // Only the source code is registered here; the clock itself is switched by
  // the external mux, which sees the code follow misc_output and clock_select_bit4 every cycle, not only under synchronous reset.
  always @(posedge clock) begin
    if (reset) begin
      selected_clock_src <= `DECC_SRC_PRIMARY;
    end else begin
      selected_clock_src <= src_d;
    end
  end

  // ****************************************************************
  // Decode enables
  // ****************************************************************
  always @(posedge clock) begin
    if (reset) begin
      io_decode_en <= `DECC_RST1;
    end else begin
      io_decode_en <= board_enable_pin && compatibility_options_q[`DECC_CP_DECODE];
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      mem_decode_en <= `DECC_RST1;
    end else begin
      mem_decode_en <= board_enable_pin && compatibility_options_q[`DECC_CP_DECODE]
                       && ext_enable_bit;
    end
  end

  // ****************************************************************
  // Display enable skew and refresh start
  // ****************************************************************
  always @(posedge clock) begin
    if (reset) begin
      de_skew_chars <= `DECC_RST3;
    end else begin
      de_skew_chars <= {1'b0, hblank_skew}
                       + {2'b00, compatibility_options_q[`DECC_CP_DE_SKEW]};
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      refresh_after_unskewed <= `DECC_RST1;
    end else begin
      refresh_after_unskewed <= compatibility_options_q[`DECC_CP_REF_SKEW];
    end
  end

  // ****************************************************************
  // Solid fill colours
  // ****************************************************************
  always @(posedge clock) begin
    if (reset) begin
      solid_fill_active <= `DECC_RST1;
      fg_color          <= `DECC_RST4;
      bg_color          <= `DECC_RST4;
    end else begin
      solid_fill_active <= is_solid(fb_mode);
      fg_color          <= is_solid(fb_mode) ? fg_q : `DECC_RST4;
      bg_color          <= is_solid(fb_mode) ? bg_q : `DECC_RST4;
    end
  end

  // ****************************************************************
  // Extended attributes
  // ****************************************************************
  always @(posedge clock) begin
    if (reset) begin
      attr_underline   <= `DECC_RST1;
      attr_reverse     <= `DECC_RST1;
      attr_overline    <= `DECC_RST1;
      attr_blink       <= `DECC_RST1;
      attr_alt_palette <= `DECC_RST1;
      attr_font        <= `DECC_RST3;
    end else if (compatibility_options_q[`DECC_CP_XATTR_EN]) begin
      attr_underline   <= attr_byte[`DECC_AT_UNDERLINE];
      attr_reverse     <= attr_byte[`DECC_AT_REVERSE];
      attr_overline    <= attr_byte[`DECC_AT_OVERLINE];
      attr_blink       <= attr_byte[`DECC_AT_BLINK];
      attr_alt_palette <= attr_byte[`DECC_AT_PALETTE];
      attr_font        <= attr_byte[`DECC_AT_FONT_HI:`DECC_AT_FONT_LO];
    end else begin
      attr_underline   <= `DECC_RST1;
      attr_reverse     <= `DECC_RST1;
      attr_overline    <= `DECC_RST1;
      attr_blink       <= `DECC_RST1;
      attr_alt_palette <= `DECC_RST1;
      attr_font        <= `DECC_RST3;
    end
  end

  // The address paths stay combinational so that CPU and CRTC accesses see a
  // new mode in the same cycle as the stored compatibility bits.
  decc_addr_mux u_addr_mux (
    .cpu_addr       (cpu_addr),
    .crtc_count     (crtc_count),
    .crtc_std_addr  (crtc_std_addr),
    .compatibility_options         (compatibility_options_q),
    .page_sel       (page_q),
    .misc_page_bit  (misc_output[1]),
    .chain4         (chain4),
    .chain_odd_even (chain_odd_even),
    .doubleword     (doubleword),
    .cpu_linear     (cpu_linear),
    .crtc_linear    (crtc_linear)
  );
endmodule

//--- design/decc_map.vh
// Register indices, field positions and reset values of the clock and address extension bank.
`ifndef DECC_MAP_VH
`define DECC_MAP_VH
`define DECC_IDX_CLOCK_MUX_CONTROL     8'hF8
`define DECC_IDX_PAGE        8'hF9
`define DECC_IDX_FG          8'hFA
`define DECC_IDX_BG          8'hFB
`define DECC_IDX_COMPATIBILITY_OPTIONS      8'hFC
`define DECC_UNLOCK_VAL      8'hEA
`define DECC_RST8            8'h00
`define DECC_RST4            4'h0
`define DECC_MASK_PAGE       8'h01
`define DECC_MASK_COLOR      8'h0F
`define DECC_MASK_FULL       8'hFF
`define DECC_RST1            1'h0
`define DECC_RST3            3'h0
`define DECC_PAGE_BIT        0
`define DECC_COLOR_HI        3
`define DECC_COLOR_LO        0
`define DECC_FB_SOLID        2'h1
// Miscellaneous output register bits seen by this bank.
`define DECC_MISC_SEL_HI     3
`define DECC_MISC_SEL_LO     2
// Extended clock pin drive levels.
`define DECC_PINS_IDLE       3'h0
`define DECC_PINS_DRIVE      3'h7
// Extended attribute byte fields.
`define DECC_AT_UNDERLINE    7
`define DECC_AT_REVERSE      6
`define DECC_AT_OVERLINE     5
`define DECC_AT_BLINK        4
`define DECC_AT_PALETTE      3
`define DECC_AT_FONT_HI      2
`define DECC_AT_FONT_LO      0
// Clock control fields.
`define DECC_CK_OUT_HI       7
`define DECC_CK_OUT_LO       5
`define DECC_CK_CLK3_ON      4
`define DECC_CK_EXT_OVR      3
`define DECC_CK_OUT_SRC      2
`define DECC_CK_DIR          1
`define DECC_CK_ZERO_ONLY    0
// Compatibility fields.
`define DECC_CP_DECODE       7
`define DECC_CP_DE_SKEW      6
`define DECC_CP_SEQ_CHAIN    5
`define DECC_CP_REF_SKEW     4
`define DECC_CP_SEQ_CHAIN4   3
`define DECC_CP_X256_EN      2
`define DECC_CP_X256_MODE    1
`define DECC_CP_XATTR_EN     0
// Clock source codes on the selected-clock output.
`define DECC_SRC_W           4
`define DECC_SRC_PRIMARY     4'h0
`define DECC_SRC_SECOND      4'h1
`define DECC_SRC_FEATURE     4'h2
`define DECC_SRC_THIRD       4'h3
`define DECC_SRC_GROUND      4'hF
`define DECC_SRC_GEN_BASE    4'h8
`define DECC_SRC_PIN_BASE    4'h4
`endif

//--- design/decc_addr_mux.v
// CPU and CRTC linear address multiplexing for extended chain and 256-colour modes.
`include "decc_map.vh"
module decc_addr_mux (
  input  wire [16:0] cpu_addr,
  input  wire [15:0] crtc_count,
  input  wire [15:0] crtc_std_addr,
  input  wire [7:0]  compatibility_options,
  input  wire        page_sel,
  input  wire        misc_page_bit,
  input  wire        chain4,
  input  wire        chain_odd_even,
  input  wire        doubleword,
  output reg  [15:0] cpu_linear,
  output reg  [15:0] crtc_linear
);
  wire x256_en = compatibility_options[`DECC_CP_X256_EN];
  wire x256_md = compatibility_options[`DECC_CP_X256_MODE];

  always @* begin
    cpu_linear = cpu_addr[15:0];
    if (chain4) begin
      if (x256_en && !x256_md) begin
        cpu_linear = {cpu_addr[15:2], misc_page_bit, page_sel};
      end else if (x256_en && x256_md) begin
        cpu_linear = {cpu_addr[15:2], page_sel, cpu_addr[16]};
      end else if (compatibility_options[`DECC_CP_SEQ_CHAIN4]) begin
        cpu_linear = {cpu_addr[1:0], cpu_addr[15:2]};
      end
    end else if (chain_odd_even && compatibility_options[`DECC_CP_SEQ_CHAIN]) begin
      cpu_linear = {cpu_addr[1:0], cpu_addr[15:2]};
    end
  end

  always @* begin
    crtc_linear = crtc_std_addr;
    if (x256_en && doubleword) begin
      crtc_linear = {crtc_std_addr[15:2], crtc_count[15], crtc_count[14]};
    end
  end
endmodule

//--- verif/decc_checker.sv
// Port checks for the extension register bank.
module decc_checker (
  input logic       clock,
  input logic       reset,
  input logic [7:0] reg_index,
  input logic       reg_read,
  input logic       ext_unlocked,
  input logic [7:0] reg_rdata,
  input logic       board_enable_pin,
  input logic       ext_enable_bit,
  input logic       io_decode_en,
  input logic       mem_decode_en,
  input logic [1:0] fb_mode,
  input logic [3:0] fg_color,
  input logic [3:0] bg_color,
  input logic       solid_fill_active,
  input logic [1:0] hblank_skew,
  input logic [2:0] de_skew_chars
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Properties
  // ****
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_rd_page;
    reg_read && ext_unlocked && reg_index == 8'hF9;
  endsequence
  sequence s_rd_color;
    reg_read && ext_unlocked && (reg_index == 8'hFA || reg_index == 8'hFB);
  endsequence
  chk_pin_off: assert property (!board_enable_pin |=> !io_decode_en && !mem_decode_en)
    else $error("decode enabled with board pin low");
  chk_mem_gate: assert property (!ext_enable_bit |=> !mem_decode_en)
    else $error("memory decode enabled with external bit low");
  chk_mem_io: assert property (mem_decode_en |-> io_decode_en)
    else $error("memory decode without io decode");
  chk_locked_read: assert property (reg_read && !ext_unlocked |=> reg_rdata == 8'h00)
    else $error("locked read returned data");
  chk_page_rsvd: assert property (s_rd_page |=> reg_rdata[7:1] == 7'h00)
    else $error("page reserved bits not zero");
  chk_color_rsvd: assert property (s_rd_color |=> reg_rdata[7:4] == 4'h0)
    else $error("colour reserved bits not zero");
  chk_not_solid: assert property (fb_mode != 2'h1 |=> !solid_fill_active && bg_color == 4'h0 && fg_color == 4'h0)
    else $error("solid fill outputs outside solid mode");
  chk_solid_on: assert property (fb_mode == 2'b01 |=> solid_fill_active)
    else $error("solid fill mode not flagged");
  chk_skew_step: assert property (1'b1 |=> (de_skew_chars - {1'b0, $past(hblank_skew)}) <= 3'h1)
    else $error("display enable skew not programmed skew or one more");
endmodule

bind decc_ext_regs decc_checker i_decc_checker (.*);

//--- verif/decc_host.sv
// Host model that reaches the bank through the indexed data port.
module decc_host (
  input  logic       clock,
  output logic [7:0] reg_index,
  output logic [7:0] reg_wdata,
  output logic       reg_write,
  output logic       reg_read,
  input  logic [7:0] reg_rdata,
  output logic       ext_unlocked,
  output logic       sync_reset_active
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Port cycles
  // ****
  // A careless host may leave synchronous reset low; only one scenario clears obey.
  logic obey = 1'b1;
  initial begin
    {reg_index, reg_wdata, reg_write, reg_read, ext_unlocked, sync_reset_active} = '0;
  end
  task automatic unlock;
    ext_unlocked = 1'b1;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(negedge clock);
    if (idx == 8'hF8 && obey) sync_reset_active = 1'b1;
    reg_index = idx;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    reg_index = ~idx;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    @(negedge clock);
    reg_index = idx;
    reg_read = 1'b1;
    @(negedge clock);
    d = reg_rdata;
    reg_read = 1'b0;
    reg_index = ~idx;
  endtask
endmodule

//--- verif/tb.sv
// Self-checking bench for the extension register bank.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Bench
  // ****
  logic        clock, reset, reg_write, reg_read, ext_unlocked, sync_reset_active;
  logic        clock_select_bit4, board_enable_pin, ext_enable_bit, chain4;
  logic        chain_odd_even, doubleword, io_decode_en, mem_decode_en, solid_fill_active;
  logic        refresh_after_unskewed, attr_underline, attr_reverse, attr_overline;
  logic        attr_blink, attr_alt_palette;
  logic [1:0]  hblank_skew, fb_mode;
  logic [2:0]  ext_clk_pin_in, ext_clk_pin_out, ext_clk_pin_oe, de_skew_chars, attr_font;
  logic [3:0]  selected_clock_src, fg_color, bg_color;
  logic [7:0]  reg_index, reg_wdata, reg_rdata, misc_output, attr_byte;
  logic [15:0] crtc_count, crtc_std_addr, cpu_linear, crtc_linear;
  logic [16:0] cpu_addr;
  int          num_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  decc_ext_regs i_decc_ext_regs (.*);
  decc_host i_decc_host (.*);
  always #2 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      final_report;
    end
  end
  task automatic final_report;
    $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic settle;
    repeat (3) @(negedge clock);
  endtask
  task automatic t_regs;
    logic [7:0] d;
    logic [7:0] ix [5] = '{8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC};
    logic [7:0] mk [5] = '{8'hFF, 8'h01, 8'h0F, 8'h0F, 8'hFF};
    i_decc_host.wr(8'hF9, 8'hFF);
    i_decc_host.rd(8'hF9, d);
    i_decc_host.unlock();
    i_decc_host.rd(8'hF9, d);
    chk("locked_write", d, 8'h00);
    for (int i = 0; i < 5; i++) begin
      i_decc_host.rd(ix[i], d);
      chk("reset_value", d, 8'h00);
      i_decc_host.wr(ix[i], 8'hFF);
      i_decc_host.rd(ix[i], d);
      chk("readback", d, mk[i]);
      i_decc_host.wr(ix[i], 8'h00);
    end
    i_decc_host.rd(8'hF7, d);
    chk("unmapped", d, 8'h00);
  endtask
  task automatic t_clock;
    logic [7:0] ck [8] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h10, 8'h08, 8'h02, 8'h00};
    logic [7:0] ms [8] = '{8'h0C, 8'h08, 8'h00, 8'h0C, 8'h0C, 8'h08, 8'h04, 8'h04};
    logic       cs [8] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
    logic [3:0] ex [8] = '{4'hF, 4'h2, 4'h0, 4'hF, 4'h3, 4'h6, 4'hD, 4'h1};
    misc_output = 8'h04;
    clock_select_bit4 = 1'b1;
    i_decc_host.wr(8'hF8, 8'h46);
    settle;
    chk("pin_out", ext_clk_pin_out, 3'b010);
    chk("pin_oe", ext_clk_pin_oe, 3'b111);
    i_decc_host.wr(8'hF8, 8'h42);
    settle;
    chk("pin_select", ext_clk_pin_out, 3'b101);
    i_decc_host.obey = 1'b0;
    i_decc_host.sync_reset_active = 1'b0;
    i_decc_host.wr(8'hF8, 8'h00);
    settle;
    chk("oe_held", ext_clk_pin_oe, 3'b111);
    i_decc_host.sync_reset_active = 1'b1;
    i_decc_host.obey = 1'b1;
    settle;
    chk("oe_input", ext_clk_pin_oe, 3'b000);
    for (int i = 0; i < 8; i++) begin
      misc_output = ms[i];
      clock_select_bit4 = cs[i];
      i_decc_host.wr(8'hF8, ck[i]);
      settle;
      chk("clock_src", selected_clock_src, ex[i]);
    end
  endtask
  task automatic t_decode;
    logic       p [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
    logic       e [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    logic [7:0] c [4] = '{8'h80, 8'h00, 8'h80, 8'h80};
    logic [1:0] x [4] = '{2'd0, 2'd0, 2'd3, 2'd2};
    for (int i = 0; i < 4; i++) begin
      board_enable_pin = p[i];
      ext_enable_bit = e[i];
      i_decc_host.wr(8'hFC, c[i]);
      settle;
      chk("decode", {io_decode_en, mem_decode_en}, x[i]);
    end
  endtask
  task automatic am(input logic [7:0] c, input logic c4, input logic oe, input logic [15:0] x);
    chain4 = c4;
    chain_odd_even = oe;
    i_decc_host.wr(8'hFC, c);
    settle;
    chk("cpu_linear", cpu_linear, x);
  endtask
  task automatic t_addr;
    misc_output = 8'h00;
    cpu_addr = 17'h0A5A7;
    crtc_count = 16'h8000;
    doubleword = 1'b1;
    i_decc_host.wr(8'hF9, 8'h01);
    am(8'h04, 1'b1, 1'b0, {cpu_addr[15:2], 2'b01});
    chk("crtc_low", crtc_linear[1:0], 2'b10);
    am(8'h06, 1'b1, 1'b0, {cpu_addr[15:2], 1'b1, cpu_addr[16]});
    am(8'h06, 1'b0, 1'b0, cpu_addr[15:0]);
    am(8'h20, 1'b0, 1'b1, {cpu_addr[1:0], cpu_addr[15:2]});
    am(8'h08, 1'b1, 1'b0, {cpu_addr[1:0], cpu_addr[15:2]});
  endtask
  task automatic t_misc;
    hblank_skew = 2'd2;
    i_decc_host.wr(8'hFC, 8'h50);
    settle;
    chk("skew", {refresh_after_unskewed, de_skew_chars}, 4'hB);
    i_decc_host.wr(8'hFA, 8'h5C);
    i_decc_host.wr(8'hFB, 8'hA3);
    fb_mode = 2'b01;
    attr_byte = 8'hA5;
    i_decc_host.wr(8'hFC, 8'h01);
    settle;
    chk("skew_off", {refresh_after_unskewed, de_skew_chars}, 4'h2);
    chk("colors", {fg_color, bg_color}, 8'hC3);
    chk("attr", {attr_underline, attr_reverse, attr_overline, attr_blink,
                 attr_alt_palette, attr_font}, 8'hA5);
    fb_mode = 2'b00;
    i_decc_host.wr(8'hFC, 8'h00);
    settle;
    chk("attr_off", {attr_underline, attr_reverse, attr_font}, 5'h00);
  endtask
  initial begin
    {clock, clock_select_bit4, board_enable_pin, ext_enable_bit, chain4} = '0;
    {chain_odd_even, doubleword, hblank_skew, fb_mode, ext_clk_pin_in} = '0;
    {misc_output, attr_byte, crtc_count, crtc_std_addr, cpu_addr} = '0;
    reset = 1'b1;
    repeat (10) @(negedge clock);
    reset = 1'b0;
    t_regs;
    t_clock;
    t_decode;
    t_addr;
    t_misc;
    final_report;
  end
endmodule
